// >>> src/bcd_port_pkg.sv
package bcd_port_pkg;

    // System clock rate and the millisecond timebase derived from it
    localparam int CLK_HZ     = 125_000_000;
    localparam int CYC_PER_MS = CLK_HZ / 1000;

    // Handshake times in milliseconds, as the reader sees them
    localparam int SETUP_MS   = 30; // Request rise to data and strobe
    localparam int VALID_MS   = 40; // Strobe high time
    localparam int OFF_MS     = 16; // Strobe fall to data release
    localparam int REPEAT_MS  = 64; // Strobe-to-strobe period while requested
    localparam int REQ_GAP_MS = 20; // Reader's least wait before a new request

    // Counter width and last-count compare values for each phase
    localparam int MS_W = 7;
    localparam logic [MS_W-1:0] SETUP_LAST = MS_W'(SETUP_MS - 1);
    localparam logic [MS_W-1:0] VALID_LAST = MS_W'(VALID_MS - 1);
    localparam logic [MS_W-1:0] OFF_LAST   = MS_W'(OFF_MS - 1);
    localparam logic [MS_W-1:0] GAP_LAST   = MS_W'(REPEAT_MS - VALID_MS - 1);
    localparam logic [MS_W-1:0] MS_ZERO    = 7'h00;

    // Six BCD digits of measurement data
    localparam int DIGITS = 6;
    localparam int DATA_W = 4 * DIGITS;
    localparam logic [DATA_W-1:0] DATA_OFF = 24'h000000;

    // Prescaler width for the millisecond tick
    localparam int TICK_W = 24;
    localparam logic [TICK_W-1:0] TICK_ZERO = 24'h000000;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SETUP,
        ST_VALID,
        ST_GAP
    } phase_t;

    typedef struct packed {
        phase_t            phase;
        logic [MS_W-1:0]   ms_cnt;
        logic [DATA_W-1:0] data;
        logic              valid;
        logic              data_on;
        logic              req_meta;
        logic              req_sync;
        logic              req_last;
        logic              hold_meta;
        logic              hold_sync;
    } port_state_t;

    typedef struct packed {
        logic [TICK_W-1:0] cnt;
        logic              tick;
    } tick_state_t;

    localparam port_state_t PORT_RESET = '{
        phase:     ST_IDLE,
        ms_cnt:    MS_ZERO,
        data:      DATA_OFF,
        valid:     1'b0,
        data_on:   1'b0,
        req_meta:  1'b0,
        req_sync:  1'b0,
        req_last:  1'b0,
        hold_meta: 1'b0,
        hold_sync: 1'b0
    };

endpackage : bcd_port_pkg

// >>> src/ms_tick.sv
module ms_tick #(
    parameter int TICK_CYC = bcd_port_pkg::CYC_PER_MS
) (
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic restart,
    output logic      tick
);

    localparam logic [bcd_port_pkg::TICK_W-1:0] TICK_TOP = bcd_port_pkg::TICK_W'(TICK_CYC - 1);

    bcd_port_pkg::tick_state_t st_reg;
    bcd_port_pkg::tick_state_t st_next;

    // Restart realigns the prescaler so phase lengths are whole milliseconds
    always_comb begin
        st_next      = st_reg;
        st_next.tick = 1'b0;
        if (restart) begin
            st_next.cnt = bcd_port_pkg::TICK_ZERO;
        end else if (st_reg.cnt == TICK_TOP) begin
            st_next.cnt  = bcd_port_pkg::TICK_ZERO;
            st_next.tick = 1'b1;
        end else begin
            st_next.cnt = st_reg.cnt + 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg <= '{cnt: bcd_port_pkg::TICK_ZERO, tick: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign tick = st_reg.tick;

    AST_TICK_SINGLE: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (tick && TICK_CYC > 1) |=> !tick)
        else $error("Millisecond tick lasted more than one cycle");

endmodule : ms_tick

// >>> src/bcd_request_output_port.sv
module bcd_request_output_port #(
    parameter int TICK_CYC = bcd_port_pkg::CYC_PER_MS
) (
    input  wire logic                            clk_sys,
    input  wire logic                            sys_rst,
    input  wire logic                            request_in,
    input  wire logic                            hold_in,
    input  wire logic [bcd_port_pkg::DATA_W-1:0] meas_value,
    output logic      [bcd_port_pkg::DATA_W-1:0] bcd_data,
    output logic                                 data_valid,
    output logic                                 data_on
);

    bcd_port_pkg::port_state_t st_reg;
    bcd_port_pkg::port_state_t st_next;

    logic tick;
    logic restart;
    logic req_rise;

    // Millisecond timebase, realigned at the request edge
    ms_tick #(
        .TICK_CYC (TICK_CYC)
    ) u_ms_tick (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .restart (restart),
        .tick    (tick)
    );

    // Edge of the synchronised request; the meta stage feeds only the sync stage
    assign req_rise = st_reg.req_sync && !st_reg.req_last;
    assign restart  = (st_reg.phase == bcd_port_pkg::ST_IDLE) && req_rise;

    // Next-state logic for the whole port
    always_comb begin
        st_next           = st_reg;
        st_next.req_meta  = request_in;
        st_next.req_sync  = st_reg.req_meta;
        st_next.req_last  = st_reg.req_sync;
        st_next.hold_meta = hold_in;
        st_next.hold_sync = st_reg.hold_meta;
        case (st_reg.phase)
            bcd_port_pkg::ST_IDLE: begin
                st_next.valid   = 1'b0;
                st_next.data_on = 1'b0;
                st_next.data    = bcd_port_pkg::DATA_OFF;
                if (req_rise) begin
                    st_next.phase  = bcd_port_pkg::ST_SETUP;
                    st_next.ms_cnt = bcd_port_pkg::MS_ZERO;
                end
            end
            bcd_port_pkg::ST_SETUP: begin
                if (tick) begin
                    if (st_reg.ms_cnt == bcd_port_pkg::SETUP_LAST) begin
                        // First value is always fresh: a held old value does not exist yet
                        st_next.data    = meas_value;
                        st_next.valid   = 1'b1;
                        st_next.data_on = 1'b1;
                        st_next.phase   = bcd_port_pkg::ST_VALID;
                        st_next.ms_cnt  = bcd_port_pkg::MS_ZERO;
                    end else begin
                        st_next.ms_cnt = st_reg.ms_cnt + 1'b1;
                    end
                end
            end
            bcd_port_pkg::ST_VALID: begin
                if (tick) begin
                    if (st_reg.ms_cnt == bcd_port_pkg::VALID_LAST) begin
                        st_next.valid  = 1'b0;
                        st_next.phase  = bcd_port_pkg::ST_GAP;
                        st_next.ms_cnt = bcd_port_pkg::MS_ZERO;
                    end else begin
                        st_next.ms_cnt = st_reg.ms_cnt + 1'b1;
                    end
                end
            end
            bcd_port_pkg::ST_GAP: begin
                if (tick) begin
                    if (!st_reg.req_sync && st_reg.ms_cnt >= bcd_port_pkg::OFF_LAST) begin
                        st_next.data_on = 1'b0;
                        st_next.data    = bcd_port_pkg::DATA_OFF;
                        st_next.phase   = bcd_port_pkg::ST_IDLE;
                        st_next.ms_cnt  = bcd_port_pkg::MS_ZERO;
                    end else if (st_reg.ms_cnt == bcd_port_pkg::GAP_LAST) begin
                        // Swap straight from old to new value; the lines never pass through zero
                        if (!st_reg.hold_sync) begin
                            st_next.data = meas_value;
                        end
                        st_next.valid  = 1'b1;
                        st_next.phase  = bcd_port_pkg::ST_VALID;
                        st_next.ms_cnt = bcd_port_pkg::MS_ZERO;
                    end else begin
                        st_next.ms_cnt = st_reg.ms_cnt + 1'b1;
                    end
                end
            end
            default: begin
                st_next = bcd_port_pkg::PORT_RESET;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg <= bcd_port_pkg::PORT_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs come straight from the state register
    assign bcd_data   = st_reg.data;
    assign data_valid = st_reg.valid;
    assign data_on    = st_reg.data_on;

    // Checks on the handshake timing, counted in millisecond ticks, and on the data values shown

    AST_IDLE_QUIET: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (st_reg.phase == bcd_port_pkg::ST_IDLE && $past(st_reg.phase) == bcd_port_pkg::ST_IDLE)
        |-> (!data_valid && !data_on && bcd_data == bcd_port_pkg::DATA_OFF))
        else $error("Output active without a request cycle");

    AST_REQ_STARTS: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (st_reg.phase == bcd_port_pkg::ST_IDLE && req_rise)
        |=> (st_reg.phase == bcd_port_pkg::ST_SETUP && st_reg.ms_cnt == bcd_port_pkg::MS_ZERO))
        else $error("Request edge did not start a cycle");

    AST_SETUP_TIME: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ($rose(data_valid) && $past(st_reg.phase) == bcd_port_pkg::ST_SETUP)
        |-> ($past(tick) && $past(st_reg.ms_cnt) == bcd_port_pkg::SETUP_LAST && data_on))
        else $error("Strobe did not follow the 30 ms setup");

    AST_VALID_TIME: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $fell(data_valid)
        |-> ($past(tick) && $past(st_reg.ms_cnt) == bcd_port_pkg::VALID_LAST
             && st_reg.phase == bcd_port_pkg::ST_GAP))
        else $error("Strobe width not 40 ms");

    AST_DATA_RELEASE: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $fell(data_on)
        |-> ($past(st_reg.phase) == bcd_port_pkg::ST_GAP
             && $past(st_reg.ms_cnt) >= bcd_port_pkg::OFF_LAST && !$past(st_reg.req_sync)
             && bcd_data == bcd_port_pkg::DATA_OFF))
        else $error("Data released early or while requested");

    AST_REPEAT_TIME: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ($rose(data_valid) && $past(st_reg.phase) == bcd_port_pkg::ST_GAP)
        |-> ($past(st_reg.ms_cnt) == bcd_port_pkg::GAP_LAST && $past(st_reg.req_sync)))
        else $error("Repeat strobe not on the 64 ms period");

    AST_NO_LOW_SWAP: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (st_reg.phase == bcd_port_pkg::ST_VALID || st_reg.phase == bcd_port_pkg::ST_GAP)
        |-> data_on)
        else $error("Data lines dropped during an output cycle");

    AST_HOLD_KEEPS: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ($rose(data_valid) && $past(st_reg.phase) == bcd_port_pkg::ST_GAP && $past(st_reg.hold_sync))
        |-> $stable(bcd_data))
        else $error("Held value changed at a changeover");

    AST_LATCH_NEW: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ($rose(data_valid) && !($past(st_reg.phase) == bcd_port_pkg::ST_GAP && $past(st_reg.hold_sync)))
        |-> (bcd_data == $past(meas_value)))
        else $error("Output cycle did not latch the measurement");

    AST_DATA_STEADY: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $changed(bcd_data) |-> ($rose(data_valid) || $fell(data_on)))
        else $error("Data changed outside a cycle start or release");

    // A changeover must land on the old or the new value, with the lines still driven
    AST_SWAP_OLD_OR_NEW: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ($rose(data_valid) && $past(st_reg.phase) == bcd_port_pkg::ST_GAP)
        |-> (data_on && (bcd_data == $past(bcd_data) || bcd_data == $past(meas_value))))
        else $error("Changeover showed neither the old nor the new value");

    // Nothing reaches the lines while the setup time runs
    AST_SETUP_QUIET: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (st_reg.phase == bcd_port_pkg::ST_SETUP)
        |-> (!data_valid && !data_on && bcd_data == bcd_port_pkg::DATA_OFF))
        else $error("Data or strobe shown before the setup time ended");

    // Strobe level follows the phase exactly
    AST_VALID_PHASE: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (st_reg.phase == bcd_port_pkg::ST_VALID) |-> (data_valid && data_on))
        else $error("Strobe or data missing in the strobe phase");

    AST_GAP_PHASE: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (st_reg.phase == bcd_port_pkg::ST_GAP) |-> !data_valid)
        else $error("Strobe still high in the gap");

    // The millisecond count never runs past the last count of its phase
    AST_CNT_RANGE: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (st_reg.phase == bcd_port_pkg::ST_SETUP && st_reg.ms_cnt <= bcd_port_pkg::SETUP_LAST)
        || (st_reg.phase == bcd_port_pkg::ST_VALID && st_reg.ms_cnt <= bcd_port_pkg::VALID_LAST)
        || (st_reg.phase == bcd_port_pkg::ST_GAP && st_reg.ms_cnt <= bcd_port_pkg::GAP_LAST)
        || (st_reg.phase == bcd_port_pkg::ST_IDLE && st_reg.ms_cnt == bcd_port_pkg::MS_ZERO))
        else $error("Millisecond count outside its phase range");

    // Main scenarios
    COV_FIRST_STROBE: cover property (@(posedge clk_sys) disable iff (sys_rst)
        $rose(data_valid) && $past(st_reg.phase) == bcd_port_pkg::ST_SETUP);
    COV_SINGLE: cover property (@(posedge clk_sys) disable iff (sys_rst)
        $fell(data_on));
    COV_REPEAT: cover property (@(posedge clk_sys) disable iff (sys_rst)
        $rose(data_valid) && $past(st_reg.phase) == bcd_port_pkg::ST_GAP);
    COV_HOLD_SWAP: cover property (@(posedge clk_sys) disable iff (sys_rst)
        $rose(data_valid) && $past(st_reg.phase) == bcd_port_pkg::ST_GAP && $past(st_reg.hold_sync));

endmodule : bcd_request_output_port

// >>> testbench/reader_model.sv
module reader_model #(
    parameter int GAP = 80
) (
    input  wire logic                            clk_sys,
    input  wire logic                            want,
    input  wire logic                            data_valid,
    input  wire logic [bcd_port_pkg::DATA_W-1:0] bcd_data,
    output logic                                 request_in,
    output logic      [bcd_port_pkg::DATA_W-1:0] seen
);
    timeunit 1ns;
    timeprecision 1ps;

    int   since = 32'h00100000;
    logic dv_q  = 1'b0;

    // A new request waits out the gap after the strobe falls; a held request stays up
    always @(posedge clk_sys) begin
        dv_q  <= data_valid;
        since <= (dv_q && !data_valid) ? 0 : since + 1;
        if (!want) begin
            request_in <= 1'b0;
        end else if (since >= GAP) begin
            request_in <= 1'b1;
        end
        // Data is taken only once the strobe is up, never while it settles
        if (data_valid && !dv_q) begin
            seen <= bcd_data;
        end
    end
endmodule : reader_model

// >>> testbench/bcd_request_output_port_tb_top.sv
module bcd_request_output_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int T = 4;
    localparam int W = bcd_port_pkg::DATA_W;

    logic         clk_sys = 1'b0;
    logic         sys_rst = 1'b1;
    logic         want    = 1'b0;
    logic         hold_in = 1'b0;
    logic [W-1:0] meas_value = 24'h000000;
    logic [W-1:0] bcd_data;
    logic [W-1:0] seen;
    logic [W-1:0] cur;
    logic [W-1:0] exp_last;
    logic [W-1:0] exp_q[$];
    logic         request_in;
    logic         data_valid;
    logic         data_on;
    logic         dv_p = 1'b0;
    logic         on_p = 1'b0;
    logic         rq_p = 1'b0;
    logic [31:0]  lfsr = 32'h00007f20;
    int           error_cnt   = 0;
    int           check_count = 0;
    int           cyc = 0;
    int           t_req = 0;
    int           t_rise = 0;
    int           t_fall = 0;

    // Clock
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end

    bcd_request_output_port #(.TICK_CYC(T)) u_dut (
        .clk_sys    (clk_sys),
        .sys_rst    (sys_rst),
        .request_in (request_in),
        .hold_in    (hold_in),
        .meas_value (meas_value),
        .bcd_data   (bcd_data),
        .data_valid (data_valid),
        .data_on    (data_on)
    );

    reader_model #(.GAP(20 * T)) u_reader (
        .clk_sys    (clk_sys),
        .want       (want),
        .data_valid (data_valid),
        .bcd_data   (bcd_data),
        .request_in (request_in),
        .seen       (seen)
    );

    // Digits forced valid and the lowest one odd, so a value is never all zero
    function automatic logic [W-1:0] bcd_of(input logic [31:0] x);
        logic [W-1:0] v;
        for (int i = 0; i < bcd_port_pkg::DIGITS; i++) begin
            v[4*i+:4] = 4'(x[4*i+:4] % 10);
        end
        v[0] = 1'b1;
        return v;
    endfunction : bcd_of

    // One step of the bench's random source
    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_step

    // New measurement; under hold the old value is what must come out
    task automatic new_val(input bit keep);
        lfsr = lfsr_step(lfsr);
        meas_value <= bcd_of(lfsr);
        if (!keep) begin
            cur = bcd_of(lfsr);
        end
        exp_q.push_back(cur);
    endtask : new_val

    task automatic chk_val(input string n, input logic [W-1:0] e, input logic [W-1:0] s);
        check_count++;
        if (s !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : chk_val

    task automatic chk_cnt(input string n, input int lo, input int hi, input int s);
        check_count++;
        if (s < lo || s > hi) begin
            error_cnt++;
            $display("mismatch %s expected %0d..%0d seen %0d", n, lo, hi, s);
        end
    endtask : chk_cnt

    task automatic results();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    // Monitor on the falling edge, clear of the launching edge's updates
    always @(negedge clk_sys) begin
        cyc++;
        if (request_in && !rq_p) t_req = cyc;
        if (data_valid && !dv_p) begin
            if (t_req > t_rise) chk_cnt("setup", 30 * T + 3, 30 * T + 5, cyc - t_req);
            else chk_cnt("period", 64 * T, 64 * T, cyc - t_rise);
            t_rise   = cyc;
            exp_last = (exp_q.size() > 0) ? exp_q.pop_front() : '0;
            chk_val("data", exp_last, bcd_data);
        end
        if (!data_valid && dv_p) begin
            t_fall = cyc;
            chk_cnt("strobe", 40 * T, 40 * T, cyc - t_rise);
            chk_val("seen", exp_last, seen);
        end
        if (!data_on && on_p) begin
            chk_cnt("release", 16 * T, 17 * T, cyc - t_fall);
            chk_val("off", '0, bcd_data);
        end
        if (data_on === 1'b1 && bcd_data === '0) chk_val("low", exp_last, bcd_data);
        dv_p = data_valid;
        on_p = data_on;
        rq_p = request_in;
    end

    // Watchdog sized well above the whole sequence
    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        results();
    end

    initial begin
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (200) @(posedge clk_sys);
        chk_val("idle", '0, W'({data_on, data_valid}));
        // Single output, request dropped while the strobe is up
        new_val(1'b0);
        want <= 1'b1;
        @(posedge data_valid);
        @(posedge clk_sys) want <= 1'b0;
        @(negedge data_on);
        repeat (2) @(posedge clk_sys);
        // Continuous output, hold across the second changeover
        new_val(1'b0);
        want <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            @(posedge data_valid);
            repeat (4) @(posedge clk_sys);
            hold_in <= (i == 1);
            new_val(i == 1);
        end
        @(posedge data_valid);
        @(posedge clk_sys) want <= 1'b0;
        @(negedge data_on);
        repeat (4) @(posedge clk_sys);
        chk_cnt("left", 0, 0, exp_q.size());
        results();
    end
endmodule : bcd_request_output_port_tb_top
